// file: logic/stc_defs.vh
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef STC_DEFS_VH
`define STC_DEFS_VH

`define STC_ADDR_W         4
`define STC_OFF_CTRL_A     4'h0
`define STC_OFF_CTRL_B     4'h1
`define STC_OFF_CTRL_C     4'h2
`define STC_OFF_CNT_L      4'h3
`define STC_OFF_CNT_H      4'h4
`define STC_OFF_CAP_L      4'h5
`define STC_OFF_CAP_H      4'h6
`define STC_OFF_CMPA_L     4'h7
`define STC_OFF_CMPA_H     4'h8
`define STC_OFF_CMPB_L     4'h9
`define STC_OFF_CMPB_H     4'hA
`define STC_OFF_CMPC_L     4'hB
`define STC_OFF_CMPC_H     4'hC
`define STC_OFF_FLAGS      4'hD
`define STC_OFF_SRC        4'hE

`define STC_B_FILT         7
`define STC_B_EDGE         6
`define STC_C_FOCA         7
`define STC_C_FOCB         6
`define STC_C_FOCC         5
`define STC_F_CAP          5
`define STC_F_CMPC         3
`define STC_F_CMPB         2
`define STC_F_CMPA         1
`define STC_F_OVF          0

`define STC_CTRL_A_RST     8'h00
`define STC_CTRL_B_RST     8'h00
`define STC_B_WMASK        8'hDF
`define STC_A_WMASK        8'hFF

`define STC_CS_STOP        3'h0
`define STC_CS_DIV1        3'h1
`define STC_CS_DIV8        3'h2
`define STC_CS_DIV64       3'h3
`define STC_CS_DIV256      3'h4
`define STC_CS_DIV1024     3'h5
`define STC_CS_EXT_FALL    3'h6
`define STC_CS_EXT_RISE    3'h7

`define STC_FILT_SAMPLES   4
`define STC_FILT_LAST      3'h3

`endif

// file: logic/stc_capture_filter.v
// Capture pin noise filter: output follows after four equal samples
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_capture_filter (
  // Clock and reset
  input  wire clk,
  input  wire sys_rst,
  // Synchronised input
  input  wire sample_in,
  // Filtered output
  output reg  filtered
);
  reg [2:0] run_len;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_len  <= 3'h0;
      filtered <= 1'b0;
    end else if (sample_in == filtered) begin
      run_len <= 3'h0;
    end else if (run_len == `STC_FILT_LAST) begin
      filtered <= sample_in;
      run_len  <= 3'h0;
    end else begin
      run_len <= run_len + 3'h1;
    end
  end
endmodule // stc_capture_filter

// file: logic/stc_timer.v
// Sixteen-bit timer with input capture, three compare channels and forced compare
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_timer (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Register port
  input  wire [3:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // Pins
  input  wire       capture_pin,
  input  wire       comparator_out,
  input  wire       external_count_pin,
  // Waveform outputs
  output reg  [2:0] waveform_output_pin,
  output reg  [2:0] waveform_output_enable
);
  // ==========================================================================
  // Registers
  reg  [7:0]  ctrl_a;
  reg  [7:0]  ctrl_b;
  reg         cap_src_comp;
  reg  [15:0] counter_value;
  reg  [15:0] capture_register;
  reg  [15:0] cmp_a;
  reg  [15:0] cmp_b;
  reg  [15:0] cmp_c;
  reg  [7:0]  high_latch;
  reg  [4:0]  flags;
  reg         cnt_written;
  reg         count_up;
  reg  [9:0]  prescale;
  reg  [9:0]  prescale_d;
  reg  [1:0]  cap_sync;
  reg  [1:0]  cmp_sync;
  reg  [1:0]  ext_sync;
  reg         ext_prev;
  reg         cap_prev;
  reg  [2:0]  wave;

  wire [3:0]  waveform_mode = {ctrl_b[4:3], ctrl_a[1:0]};
  wire [2:0]  clock_select  = ctrl_b[2:0];
  wire        capture_filter_enable = ctrl_b[`STC_B_FILT];
  wire        capture_edge_select   = ctrl_b[`STC_B_EDGE];

  // ==========================================================================
  // Mode decode
  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hC);
    end
  endfunction

  function is_phase;
    input [3:0] m;
    begin
      is_phase = (m >= 4'h1 && m <= 4'h3) || (m >= 4'h8 && m <= 4'hB);
    end
  endfunction

  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] ocra;
    input [15:0] icr;
    begin
      case (m)
        4'h1, 4'h5: top_of = 16'h00FF;
        4'h2, 4'h6: top_of = 16'h01FF;
        4'h3, 4'h7: top_of = 16'h03FF;
        4'h4, 4'h9, 4'hB, 4'hF: top_of = ocra;
        4'h8, 4'hA, 4'hC, 4'hE: top_of = icr;
        default: top_of = 16'hFFFF;
      endcase
    end
  endfunction

  function icr_is_top;
    input [3:0] m;
    begin
      icr_is_top = (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
    end
  endfunction

  // Pin action on a match in non-PWM modes
  function apply_com;
    input [1:0] com;
    input       cur;
    begin
      case (com)
        2'h1:    apply_com = ~cur;
        2'h2:    apply_com = 1'b0;
        2'h3:    apply_com = 1'b1;
        default: apply_com = cur;
      endcase
    end
  endfunction

  wire [15:0] top = top_of(waveform_mode, cmp_a, capture_register);

  // ==========================================================================
  // Synchronisers and capture filter
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_sync <= 2'h0;
      cmp_sync <= 2'h0;
      ext_sync <= 2'h0;
    end else begin
      cap_sync <= {cap_sync[0], capture_pin};
      cmp_sync <= {cmp_sync[0], comparator_out};
      ext_sync <= {ext_sync[0], external_count_pin};
    end
  end

  wire cap_raw = cap_src_comp ? cmp_sync[1] : cap_sync[1];
  wire cap_filt;

  stc_capture_filter u_filter (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .sample_in(cap_raw),
    .filtered (cap_filt)
  );

  wire cap_in = capture_filter_enable ? cap_filt : cap_raw;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cap_prev <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      cap_prev <= cap_in;
      ext_prev <= ext_sync[1];
    end
  end

  wire cap_edge = capture_edge_select ? (cap_in & ~cap_prev)
                                      : (~cap_in & cap_prev);
  wire cap_event = cap_edge & ~icr_is_top(waveform_mode);

  // ==========================================================================
  // Clock select and prescaler
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale   <= 10'h000;
      prescale_d <= 10'h000;
    end else begin
      prescale   <= prescale + 10'h001;
      prescale_d <= prescale;
    end
  end

  // Prescaler bit k rises once every 2^(k+1) clocks
  wire [9:0] pre_tick = prescale & ~prescale_d;
  reg        tick;

  always @* begin
    case (clock_select)
      `STC_CS_STOP:     tick = 1'b0;
      `STC_CS_DIV1:     tick = 1'b1;
      `STC_CS_DIV8:     tick = pre_tick[2];
      `STC_CS_DIV64:    tick = pre_tick[5];
      `STC_CS_DIV256:   tick = pre_tick[7];
      `STC_CS_DIV1024:  tick = pre_tick[9];
      `STC_CS_EXT_FALL: tick = ext_prev & ~ext_sync[1];
      `STC_CS_EXT_RISE: tick = ~ext_prev & ext_sync[1];
      default:          tick = 1'b0;
    endcase
  end

  // ==========================================================================
  // Register access decode
  wire wr_ctrl_a = reg_write && reg_addr == `STC_OFF_CTRL_A;
  wire wr_ctrl_b = reg_write && reg_addr == `STC_OFF_CTRL_B;
  wire wr_ctrl_c = reg_write && reg_addr == `STC_OFF_CTRL_C;
  wire wr_cnt_l  = reg_write && reg_addr == `STC_OFF_CNT_L;
  wire wr_cap_l  = reg_write && reg_addr == `STC_OFF_CAP_L;
  wire wr_cmpa_l = reg_write && reg_addr == `STC_OFF_CMPA_L;
  wire wr_cmpb_l = reg_write && reg_addr == `STC_OFF_CMPB_L;
  wire wr_cmpc_l = reg_write && reg_addr == `STC_OFF_CMPC_L;
  wire wr_flags  = reg_write && reg_addr == `STC_OFF_FLAGS;
  wire wr_high   = reg_write && (reg_addr == `STC_OFF_CNT_H || reg_addr == `STC_OFF_CAP_H ||
                   reg_addr == `STC_OFF_CMPA_H || reg_addr == `STC_OFF_CMPB_H ||
                   reg_addr == `STC_OFF_CMPC_H);
  wire [15:0] wr_word = {high_latch, reg_wdata};

  wire [2:0] force_strobe = wr_ctrl_c ? {reg_wdata[`STC_C_FOCA], reg_wdata[`STC_C_FOCB],
                                         reg_wdata[`STC_C_FOCC]} : 3'h0;
  wire       force_ok = ~is_pwm(waveform_mode);

  // ==========================================================================
  // Counter and compare matches
  wire [2:0] match_raw = {counter_value == cmp_a, counter_value == cmp_b,
                          counter_value == cmp_c};
  wire [2:0] match = (tick && !cnt_written) ? match_raw : 3'h0;
  wire       at_top = counter_value == top;
  reg  [15:0] next_counter_value;
  reg         next_count_up;

  always @* begin
    next_counter_value = counter_value;
    next_count_up      = count_up;
    if (tick) begin
      if (is_phase(waveform_mode)) begin
        if (count_up && at_top) begin
          next_count_up      = 1'b0;
          next_counter_value = counter_value - 16'h0001;
        end else if (!count_up && counter_value == 16'h0000) begin
          next_count_up      = 1'b1;
          next_counter_value = 16'h0001;
        end else if (count_up) begin
          next_counter_value = counter_value + 16'h0001;
        end else begin
          next_counter_value = counter_value - 16'h0001;
        end
      end else if (at_top) begin
        next_counter_value = 16'h0000;
      end else begin
        next_counter_value = counter_value + 16'h0001;
      end
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_value <= 16'h0000;
      count_up      <= 1'b1;
      cnt_written   <= 1'b0;
    end else if (wr_cnt_l) begin
      counter_value <= wr_word;
      count_up      <= 1'b1;
      cnt_written   <= 1'b1;
    end else begin
      counter_value <= next_counter_value;
      count_up      <= next_count_up;
      if (tick)
        cnt_written <= 1'b0;
    end
  end

  // ==========================================================================
  // Control, compare, capture and shared latch
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a           <= `STC_CTRL_A_RST;
      ctrl_b           <= `STC_CTRL_B_RST;
      cap_src_comp     <= 1'b0;
      cmp_a            <= 16'h0000;
      cmp_b            <= 16'h0000;
      cmp_c            <= 16'h0000;
      capture_register <= 16'h0000;
      high_latch       <= 8'h00;
    end else begin
      if (wr_ctrl_a)
        ctrl_a <= reg_wdata & `STC_A_WMASK;
      if (wr_ctrl_b)
        ctrl_b <= reg_wdata & `STC_B_WMASK;
      if (reg_write && reg_addr == `STC_OFF_SRC)
        cap_src_comp <= reg_wdata[0];
      if (wr_cmpa_l)
        cmp_a <= wr_word;
      if (wr_cmpb_l)
        cmp_b <= wr_word;
      if (wr_cmpc_l)
        cmp_c <= wr_word;
      if (cap_event)
        capture_register <= counter_value;
      else if (wr_cap_l)
        capture_register <= wr_word;
      if (wr_high)
        high_latch <= reg_wdata;
      else if (reg_read) begin
        case (reg_addr)
          `STC_OFF_CNT_L:  high_latch <= counter_value[15:8];
          `STC_OFF_CAP_L:  high_latch <= capture_register[15:8];
          `STC_OFF_CMPA_L: high_latch <= cmp_a[15:8];
          `STC_OFF_CMPB_L: high_latch <= cmp_b[15:8];
          `STC_OFF_CMPC_L: high_latch <= cmp_c[15:8];
          default:         high_latch <= high_latch;
        endcase
      end
    end
  end

  // ==========================================================================
  // Flags: hardware set wins over write-one clear
  wire [4:0] flag_set = {cap_event | (icr_is_top(waveform_mode) & tick & at_top),
                         match[0], match[1], match[2], tick & at_top};
  wire [4:0] flag_clr = wr_flags ? {reg_wdata[`STC_F_CAP], reg_wdata[`STC_F_CMPC],
                         reg_wdata[`STC_F_CMPB], reg_wdata[`STC_F_CMPA],
                         reg_wdata[`STC_F_OVF]} : 5'h00;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      flags <= 5'h00;
    else
      flags <= (flags & ~flag_clr) | flag_set;
  end

  // ==========================================================================
  // Waveform outputs
  wire [1:0] com_a = ctrl_a[7:6];
  wire [1:0] com_b = ctrl_a[5:4];
  wire [1:0] com_c = ctrl_a[3:2];
  wire [2:0] fire  = match | (force_ok ? force_strobe : 3'h0);
  reg  [2:0] next_wave;

  always @* begin
    next_wave = wave;
    if (!is_pwm(waveform_mode)) begin
      if (fire[2])
        next_wave[2] = apply_com(com_a, wave[2]);
      if (fire[1])
        next_wave[1] = apply_com(com_b, wave[1]);
      if (fire[0])
        next_wave[0] = apply_com(com_c, wave[0]);
    end else begin
      if (match[2] && com_a[1])
        next_wave[2] = com_a[0] ^ (is_phase(waveform_mode) && !count_up);
      else if (!is_phase(waveform_mode) && tick && at_top && com_a[1])
        next_wave[2] = ~com_a[0];
      if (match[1] && com_b[1])
        next_wave[1] = com_b[0] ^ (is_phase(waveform_mode) && !count_up);
      else if (!is_phase(waveform_mode) && tick && at_top && com_b[1])
        next_wave[1] = ~com_b[0];
      if (match[0] && com_c[1])
        next_wave[0] = com_c[0] ^ (is_phase(waveform_mode) && !count_up);
      else if (!is_phase(waveform_mode) && tick && at_top && com_c[1])
        next_wave[0] = ~com_c[0];
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wave                   <= 3'h0;
      waveform_output_pin    <= 3'h0;
      waveform_output_enable <= 3'h0;
    end else begin
      wave                   <= next_wave;
      waveform_output_pin    <= next_wave;
      waveform_output_enable <= {com_a != 2'h0, com_b != 2'h0, com_c != 2'h0};
    end
  end

  // ==========================================================================
  // Read data
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_read) begin
      case (reg_addr)
        `STC_OFF_CTRL_A: reg_rdata <= ctrl_a;
        `STC_OFF_CTRL_B: reg_rdata <= ctrl_b;
        `STC_OFF_CTRL_C: reg_rdata <= 8'h00;
        `STC_OFF_CNT_L:  reg_rdata <= counter_value[7:0];
        `STC_OFF_CAP_L:  reg_rdata <= capture_register[7:0];
        `STC_OFF_CMPA_L: reg_rdata <= cmp_a[7:0];
        `STC_OFF_CMPB_L: reg_rdata <= cmp_b[7:0];
        `STC_OFF_CMPC_L: reg_rdata <= cmp_c[7:0];
        `STC_OFF_CNT_H, `STC_OFF_CAP_H, `STC_OFF_CMPA_H,
        `STC_OFF_CMPB_H, `STC_OFF_CMPC_H: reg_rdata <= high_latch;
        `STC_OFF_FLAGS:  reg_rdata <= {2'h0, flags[4], 1'b0, flags[3:0]};
        `STC_OFF_SRC:    reg_rdata <= {7'h00, cap_src_comp};
        default:         reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end
endmodule // stc_timer

// file: test/stc_timer_properties.sv
// Checker of register read data and waveform outputs of the timer
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_timer_properties (
  // Clock and reset
  input wire       clk,
  input wire       sys_rst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  // Waveform outputs
  input wire [2:0] waveform_output_pin,
  input wire [2:0] waveform_output_enable
);
  // ==========================================================
  // Shadow of control A and B
  reg  [7:0] sh_a;
  reg  [7:0] sh_b;
  wire [3:0] mode = {sh_b[4:3], sh_a[1:0]};
  wire       np   = (mode == 4'h0) || (mode == 4'h4) || (mode == 4'hC);
  wire       stop = (sh_b[2:0] == 3'h0);
  wire       wr_a = reg_write && (reg_addr == `STC_OFF_CTRL_A);
  wire       frc  = reg_write && (reg_addr == `STC_OFF_CTRL_C) && stop;
  wire [2:0] en   = {|sh_a[7:6], |sh_a[5:4], |sh_a[3:2]};
  wire [2:0] pin  = waveform_output_pin;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_a <= 8'h00;
      sh_b <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == `STC_OFF_CTRL_A)
        sh_a <= reg_wdata;
      if (reg_addr == `STC_OFF_CTRL_B)
        sh_b <= reg_wdata;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_ctrlc_zero: assert property ($past(reg_read && reg_addr == `STC_OFF_CTRL_C)
    |-> reg_rdata == 8'h00) else $error("control C read not zero");
  a_ctrlb_rsvd: assert property ($past(reg_read && reg_addr == `STC_OFF_CTRL_B)
    |-> reg_rdata[5] == 1'b0) else $error("control B bit 5 read as one");
  a_enable_mode: assert property (!$past(wr_a) && !$past(wr_a, 2)
    |-> waveform_output_enable == en) else $error("output enable wrong");
  a_force_toggle: assert property (frc && reg_wdata[7] && np && sh_a[7:6] == 2'b01
    |-> ##2 pin[2] != $past(pin[2], 2)) else $error("forced toggle missing");
  a_force_level: assert property (frc && reg_wdata[6] && np && sh_a[5]
    |-> ##2 pin[1] == $past(sh_a[4], 2)) else $error("forced level wrong");
  a_force_pwm_off: assert property (frc && (reg_wdata[7:5] != 3'h0) && !np
    |-> ##1 $stable(pin) ##1 $stable(pin)) else $error("force acted in pwm mode");
  a_stopped_hold: assert property (stop && !$past(reg_write) && !$past(reg_write, 2)
    |-> $stable(pin)) else $error("output moved while stopped");
  c_force_np: cover property (frc && np && reg_wdata[7]);
  c_force_pwm: cover property (frc && !np && reg_wdata[7]);
  c_read_data: cover property ($past(reg_read) && reg_rdata != 8'h00);
endmodule // stc_timer_properties

bind stc_timer stc_timer_properties u_stc_timer_properties (
  .clk                    (clk),
  .sys_rst                (sys_rst),
  .reg_addr               (reg_addr),
  .reg_wdata              (reg_wdata),
  .reg_write              (reg_write),
  .reg_read               (reg_read),
  .reg_rdata              (reg_rdata),
  .waveform_output_pin    (waveform_output_pin),
  .waveform_output_enable (waveform_output_enable)
);

// file: test/stc_timer_tb_top.sv
// Self-checking bench of the timer with expected values written into each scenario
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_timer_tb_top;
  // ==========================================================
  // Signals
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_write = 1'b0;
  reg         reg_read = 1'b0;
  reg         capture_pin = 1'b0;
  reg         comparator_out = 1'b0;
  reg         external_count_pin = 1'b0;
  wire [7:0]  reg_rdata;
  wire [2:0]  waveform_output_pin;
  wire [2:0]  waveform_output_enable;
  integer     failures = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  integer     seed = 61545;
  integer     i;
  integer     k;
  integer     div;
  reg  [15:0] v;
  reg  [15:0] w;
  reg  [2:0]  pm = 3'h0;
  always #5 clk = ~clk;
  stc_timer u_stc_timer (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .reg_addr               (reg_addr),
    .reg_wdata              (reg_wdata),
    .reg_write              (reg_write),
    .reg_read               (reg_read),
    .reg_rdata              (reg_rdata),
    .capture_pin            (capture_pin),
    .comparator_out         (comparator_out),
    .external_count_pin     (external_count_pin),
    .waveform_output_pin    (waveform_output_pin),
    .waveform_output_enable (waveform_output_enable)
  );
  // ==========================================================
  // Tasks
  task end_sim;
    begin
      if (failures == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [15:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 d = {8'h00, reg_rdata};
    end
  endtask
  task w16(input [3:0] hi, input [15:0] d);
    begin
      wr(hi, d[15:8]);
      wr(hi - 4'h1, d[7:0]);
    end
  endtask
  task r16(input [3:0] lo, output [15:0] d);
    reg [15:0] x;
    reg [15:0] y;
    begin
      rd(lo, x);
      rd(lo + 4'h1, y);
      d = {y[7:0], x[7:0]};
    end
  endtask
  task run(input [7:0] cs, input integer n);
    begin
      wr(`STC_OFF_CTRL_B, cs);
      repeat (n) @(posedge clk);
      wr(`STC_OFF_CTRL_B, 8'h00);
    end
  endtask
  // ==========================================================
  // Timeout
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_sim;
    end
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      rd(i[3:0], w);
      chk(w, 16'h0000);
    end
    v = $random(seed);
    wr(`STC_OFF_CTRL_B, v[7:0] & 8'hD8);
    rd(`STC_OFF_CTRL_B, w);
    chk(w, {8'h00, v[7:0] & 8'hD8});
    wr(`STC_OFF_CTRL_B, 8'h00);
    wr(`STC_OFF_CTRL_C, 8'hE0);
    rd(`STC_OFF_CTRL_C, w);
    chk(w, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      k = (i == 0) ? 4 : 6 + 2 * i;
      v = $random(seed);
      w16(k[3:0], v);
      r16(k[3:0] - 4'h1, w);
      chk(w, v);
    end
    wr(`STC_OFF_CMPA_H, 8'h5A);
    wr(`STC_OFF_CMPB_L, 8'hC3);
    r16(`STC_OFF_CMPB_L, w);
    chk(w, 16'h5AC3);
    w16(`STC_OFF_CNT_H, 16'h9A21);
    rd(`STC_OFF_CNT_L, w);
    rd(`STC_OFF_CAP_H, w);
    chk(w, 16'h009A);
    for (k = 1; k < 4; k = k + 1) begin
      v = k;
      wr(`STC_OFF_CTRL_A, {v[1:0], v[1:0], v[1:0], 2'b00});
      wr(`STC_OFF_CTRL_C, 8'hE0);
      repeat (2) @(posedge clk);
      pm = (k == 1) ? ~pm : {3{v[0]}};
      #1 chk(waveform_output_pin, pm);
      chk(waveform_output_enable, 3'h7);
    end
    wr(`STC_OFF_CTRL_A, 8'h54);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`STC_OFF_CTRL_C, 8'h80 >> i);
      repeat (2) @(posedge clk);
      pm[2 - i] = ~pm[2 - i];
      #1 chk(waveform_output_pin, pm);
    end
    wr(`STC_OFF_CTRL_A, 8'h55);
    wr(`STC_OFF_CTRL_C, 8'hE0);
    repeat (3) @(posedge clk);
    #1 chk(waveform_output_pin, pm);
    wr(`STC_OFF_CTRL_B, 8'h08);
    wr(`STC_OFF_CTRL_A, 8'h54);
    wr(`STC_OFF_CTRL_C, 8'hE0);
    repeat (2) @(posedge clk);
    pm = ~pm;
    #1 chk(waveform_output_pin, pm);
    rd(`STC_OFF_FLAGS, w);
    chk(w, 16'h0000);
    rd(`STC_OFF_CNT_L, w);
    chk(w, 16'h0021);
    wr(`STC_OFF_CTRL_B, 8'h00);
    wr(`STC_OFF_CTRL_A, 8'h00);
    for (k = 1; k < 6; k = k + 1) begin
      div = (k == 1) ? 1 : (k == 2) ? 8 : (k == 3) ? 64 : (k == 4) ? 256 : 1024;
      w16(`STC_OFF_CNT_H, 16'h0000);
      v = k;
      run(v[7:0], div * 8);
      r16(`STC_OFF_CNT_L, w);
      chk((w >= 16'h0007 && w <= 16'h000A) ? 16'h0001 : 16'h0000, 16'h0001);
    end
    for (k = 6; k < 8; k = k + 1) begin
      w16(`STC_OFF_CNT_H, 16'h0000);
      v = k;
      wr(`STC_OFF_CTRL_B, v[7:0]);
      repeat (5) begin
        repeat (4) @(posedge clk);
        external_count_pin <= 1'b1;
        repeat (4) @(posedge clk);
        external_count_pin <= 1'b0;
      end
      run(v[7:0], 6);
      r16(`STC_OFF_CNT_L, w);
      chk(w, 16'h0005);
    end
    wr(`STC_OFF_CTRL_A, 8'h54);
    for (k = 8; k < 14; k = k + 2) begin
      v = ($random(seed) & 16'h1F) + 16'h1;
      w16(k[3:0], v);
    end
    w16(`STC_OFF_CNT_H, 16'h0000);
    wr(`STC_OFF_FLAGS, 8'hFF);
    run(8'h01, 50);
    pm = ~pm;
    #1 chk(waveform_output_pin, pm);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h2E, 16'h000E);
    wr(`STC_OFF_FLAGS, 8'hFF);
    w16(`STC_OFF_CMPA_H, 16'h0030);
    w16(`STC_OFF_CNT_H, 16'h0030);
    run(8'h01, 10);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h02, 16'h0000);
    chk(waveform_output_pin, pm);
    wr(`STC_OFF_FLAGS, 8'hFF);
    w16(`STC_OFF_CNT_H, 16'h002F);
    run(8'h01, 10);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h000E, 16'h0002);
    pm[2] = ~pm[2];
    chk(waveform_output_pin, pm);
    w16(`STC_OFF_CNT_H, 16'h1234);
    wr(`STC_OFF_FLAGS, 8'hFF);
    wr(`STC_OFF_CTRL_B, 8'h40);
    @(posedge clk) capture_pin <= 1'b1;
    repeat (8) @(posedge clk);
    r16(`STC_OFF_CAP_L, w);
    chk(w, 16'h1234);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h20, 16'h0020);
    w16(`STC_OFF_CNT_H, 16'h0ABC);
    wr(`STC_OFF_FLAGS, 8'hFF);
    wr(`STC_OFF_CTRL_B, 8'h80);
    @(posedge clk) capture_pin <= 1'b0;
    repeat (2) @(posedge clk);
    capture_pin <= 1'b1;
    repeat (12) @(posedge clk);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h20, 16'h0000);
    @(posedge clk) capture_pin <= 1'b0;
    repeat (14) @(posedge clk);
    r16(`STC_OFF_CAP_L, w);
    chk(w, 16'h0ABC);
    wr(`STC_OFF_SRC, 8'h01);
    w16(`STC_OFF_CNT_H, 16'h0777);
    wr(`STC_OFF_CTRL_B, 8'h40);
    @(posedge clk) comparator_out <= 1'b1;
    repeat (8) @(posedge clk);
    r16(`STC_OFF_CAP_L, w);
    chk(w, 16'h0777);
    wr(`STC_OFF_SRC, 8'h00);
    wr(`STC_OFF_FLAGS, 8'hFF);
    wr(`STC_OFF_CTRL_B, 8'h58);
    @(posedge clk) capture_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd(`STC_OFF_FLAGS, w);
    chk(w & 16'h20, 16'h0000);
    end_sim;
  end
endmodule // stc_timer_tb_top
